// ===== src/rsv_pkg.sv
// ==========================================================
// scoreboard constants
// ==========================================================
package rsv_pkg;

	// unit indices, also the rank order inside each group
	localparam int NUM_UNITS = 10;
	localparam int U_SHIFT = 0;
	localparam int U_FADD = 1;
	localparam int U_LADD = 2;
	localparam int U_BOOL = 3;
	localparam int U_DIV = 4;
	localparam int U_MUL1 = 5;
	localparam int U_MUL2 = 6;
	localparam int U_INC1 = 7;
	localparam int U_INC2 = 8;
	localparam int U_BRANCH = 9;

	// register id: {file select, index}; file 0 means no register
	localparam int REG_ID_W = 5;
	localparam logic [1:0] F_NONE = 2'h0;
	localparam logic [1:0] F_X = 2'h1;
	localparam logic [1:0] F_B = 2'h2;
	localparam logic [1:0] F_A = 2'h3;
	localparam logic [4:0] REG_NONE = 5'h00;

	// trunk sharing groups, one per unit
	localparam logic [1:0] UNIT_GROUP [0:NUM_UNITS-1] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1,
		2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
	// result trunk numbers; the branch unit stores nothing
	localparam int TRUNK_W = 11;
	localparam int UNIT_TRUNK [0:NUM_UNITS-1] = '{3, 3, 3, 7, 7, 7, 7, 10, 10, 0};
	localparam int SHIFT_B_TRUNK = 4;

	// values after reset
	localparam logic [31:0] RESV_RESET = 32'h00000000;
	localparam logic [9:0] UNIT_RESET = 10'h000;

	// instruction classes from the opcode
	typedef enum logic [2:0] {CL_BRANCH, CL_BOOL, CL_SHIFT, CL_FADD, CL_LADD, CL_MUL, CL_DIV,
		CL_INC} rsv_class_t;

endpackage

// ===== src/rsv_scoreboard.sv
// Contract
// [RULE_01] result trunks shared per group, fixed ranks
// [RULE_02] shift stores X and B results together
// [RULE_03] issue reserves every named result register
// [RULE_04] operand sources checked at execution, per class
// [RULE_05] increment float reservation only for i nonzero
// [RULE_06] second operand from address field top bits
// [RULE_07] issue stalls until unit and results free
// [RULE_08] both operands fetched together when available
// [RULE_09] stored result usable same cycle, freed after
// [RULE_10] hold write while earlier reader still waits
// [RULE_11] lowest rank wins a contended shared trunk
`timescale 1ns/1ps
module rsv_scoreboard (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic issueValid,
	input wire logic [5:0] issueOp,
	input wire logic [2:0] issueI,
	input wire logic [2:0] issueJ,
	input wire logic [2:0] issueK,
	input wire logic [2:0] issueAddrHi,
	input wire logic [9:0] unitDone,
	output logic issueTakenQ,
	output logic [3:0] issueUnitQ,
	output logic issueStallQ,
	output logic [9:0] readGoQ,
	output logic [9:0] storeGoQ,
	output logic [9:0] busyQ,
	output logic [23:0] reservedRegsQ,
	output logic [10:0] trunkActiveQ
);

	// ==========================================================
	// state
	// ==========================================================
	localparam int NU = rsv_pkg::NUM_UNITS;

	logic [31:0] resvQ, resvD; // reservation column per register id
	logic [9:0] busyD; // unit holds an instruction
	logic [9:0] readDoneQ, readDoneD; // operands fetched
	logic [9:0] writtenQ, writtenD; // result stored
	logic [9:0] readGoD, storeGoD;
	logic [10:0] trunkD;
	logic [4:0] dst0Q [NU], dst0D [NU]; // first result register
	logic [4:0] dst1Q [NU], dst1D [NU]; // second result register
	logic [4:0] src0Q [NU], src0D [NU]; // first operand register
	logic [4:0] src1Q [NU], src1D [NU]; // second operand register
	logic [9:0] depQ [NU], depD [NU]; // units whose result this one awaits
	logic [9:0] waitQ [NU], waitD [NU]; // earlier units still to fetch
	logic issueTakenD, issueStallD;
	logic [3:0] issueUnitD;

	// decoded instruction
	rsv_pkg::rsv_class_t cls;
	logic [4:0] decD0, decD1, decS0, decS1;
	int unitSel;
	logic issueOk;

	// true when a names a register and equals b
	function automatic logic sameReg(input logic [4:0] a, input logic [4:0] b);
		return (a[4:3] != rsv_pkg::F_NONE) && (a == b);
	endfunction

	assign reservedRegsQ = resvQ[31:8];

	// ==========================================================
	// instruction decode
	// ==========================================================
	// class, result and operand registers from the opcode
	always_comb begin
		logic [1:0] s0File;
		logic useHi;
		s0File = rsv_pkg::F_NONE;
		useHi = 1'b0;
		cls = rsv_pkg::CL_BRANCH;
		decD0 = rsv_pkg::REG_NONE;
		decD1 = rsv_pkg::REG_NONE;
		decS0 = rsv_pkg::REG_NONE;
		decS1 = rsv_pkg::REG_NONE;
		// [RULE_04] operand sources per class
		case (issueOp[5:3])
			3'h0: begin
				// [RULE_03] branches reserve nothing
				cls = rsv_pkg::CL_BRANCH;
				if (issueOp[2:0] == 3'h3) begin
					decS0 = {rsv_pkg::F_X, issueJ};
					decS1 = {rsv_pkg::F_X, issueK};
				end else if (issueOp[2:0] >= 3'h2) begin
					decS0 = {rsv_pkg::F_B, issueJ};
					decS1 = {rsv_pkg::F_B, issueK};
				end
			end
			3'h1: begin
				cls = rsv_pkg::CL_BOOL;
				decD0 = {rsv_pkg::F_X, issueI};
				decS0 = {rsv_pkg::F_X, issueJ};
				decS1 = {rsv_pkg::F_X, issueK};
			end
			3'h2: begin
				cls = rsv_pkg::CL_SHIFT;
				decD0 = {rsv_pkg::F_X, issueI};
				decS0 = {rsv_pkg::F_B, issueJ};
				decS1 = {rsv_pkg::F_X, issueK};
				// [RULE_03] second result for normalise forms
				if (issueOp[2:0] >= 3'h4 && issueOp[2:0] <= 3'h6) begin
					decD1 = {rsv_pkg::F_B, issueJ};
				end
			end
			3'h3: begin
				cls = (issueOp[2:0] <= 3'h5) ? rsv_pkg::CL_FADD : rsv_pkg::CL_LADD;
				decD0 = {rsv_pkg::F_X, issueI};
				decS0 = {rsv_pkg::F_X, issueJ};
				decS1 = {rsv_pkg::F_X, issueK};
			end
			3'h4: begin
				decD0 = {rsv_pkg::F_X, issueI};
				if (issueOp[2:0] == 3'h3) begin
					cls = rsv_pkg::CL_SHIFT;
					decS0 = {rsv_pkg::F_B, issueJ};
				end else begin
					cls = (issueOp[2:0] <= 3'h2) ? rsv_pkg::CL_MUL : rsv_pkg::CL_DIV;
					decS0 = {rsv_pkg::F_X, issueJ};
				end
				decS1 = {rsv_pkg::F_X, issueK};
			end
			default: begin
				cls = rsv_pkg::CL_INC;
				if (issueOp[5:3] == 3'h5) begin
					decD0 = {rsv_pkg::F_A, issueI};
					// [RULE_05] float pair only when i nonzero
					if (issueI != 3'h0) begin
						decD1 = {rsv_pkg::F_X, issueI};
					end
					case (issueOp[2:0])
						3'h0, 3'h6, 3'h7: s0File = rsv_pkg::F_A;
						3'h1, 3'h3: s0File = rsv_pkg::F_B;
						default: s0File = rsv_pkg::F_X;
					endcase
					useHi = (issueOp[2:0] <= 3'h5);
				end else begin
					decD0 = (issueOp[5:3] == 3'h6) ? {rsv_pkg::F_B, issueI} : {rsv_pkg::F_X, issueI};
					case (issueOp[2:0])
						3'h0, 3'h3: s0File = rsv_pkg::F_A;
						3'h1, 3'h4, 3'h5: s0File = rsv_pkg::F_B;
						default: s0File = rsv_pkg::F_X;
					endcase
					useHi = (issueOp[5:3] == 3'h6) ? (issueOp[2:0] != 3'h3) : (issueOp[2:0] <= 3'h2);
				end
				decS0 = {s0File, issueJ};
				// [RULE_06] k from address field top bits when useHi, else from issueK
				decS1 = {rsv_pkg::F_B, useHi ? issueAddrHi : issueK};
			end
		endcase
	end

	// ==========================================================
	// issue check
	// ==========================================================
	// pick the unit, free one of a duplexed pair
	always_comb begin
		case (cls)
			rsv_pkg::CL_BOOL: unitSel = rsv_pkg::U_BOOL;
			rsv_pkg::CL_SHIFT: unitSel = rsv_pkg::U_SHIFT;
			rsv_pkg::CL_FADD: unitSel = rsv_pkg::U_FADD;
			rsv_pkg::CL_LADD: unitSel = rsv_pkg::U_LADD;
			rsv_pkg::CL_DIV: unitSel = rsv_pkg::U_DIV;
			rsv_pkg::CL_MUL: unitSel = busyQ[rsv_pkg::U_MUL1] ? rsv_pkg::U_MUL2 : rsv_pkg::U_MUL1;
			rsv_pkg::CL_INC: unitSel = busyQ[rsv_pkg::U_INC1] ? rsv_pkg::U_INC2 : rsv_pkg::U_INC1;
			default: unitSel = rsv_pkg::U_BRANCH;
		endcase
		// [RULE_07] word present, unit free, results free
		issueOk = issueValid && !issueTakenQ && !busyQ[unitSel]
			&& !(sameReg(decD0, decD0) && resvQ[decD0])
			&& !(sameReg(decD1, decD1) && resvQ[decD1]);
	end

	// ==========================================================
	// unit tracking
	// ==========================================================
	// store grants, operand fetches, release and issue
	always_comb begin
		logic [9:0] storeReq, readReq, grant;
		logic hold;
		storeReq = '0;
		readReq = '0;
		grant = '0;
		hold = 1'b0;
		resvD = resvQ;
		busyD = busyQ;
		readDoneD = readDoneQ;
		writtenD = writtenQ;
		readGoD = '0;
		storeGoD = '0;
		trunkD = '0;
		dst0D = dst0Q;
		dst1D = dst1Q;
		src0D = src0Q;
		src1D = src1Q;
		depD = depQ;
		waitD = waitQ;
		for (int u = 0; u < NU; u++) begin
			// [RULE_10] hold while an earlier reader needs it
			hold = 1'b0;
			for (int v = 0; v < NU; v++) begin
				if (waitQ[u][v] && !readDoneQ[v] && (sameReg(src0Q[v], dst0Q[u])
					|| sameReg(src1Q[v], dst0Q[u]) || sameReg(src0Q[v], dst1Q[u])
					|| sameReg(src1Q[v], dst1Q[u]))) begin
					hold = 1'b1;
				end
			end
			storeReq[u] = busyQ[u] && readDoneQ[u] && !writtenQ[u] && unitDone[u] && !hold
				&& (u != rsv_pkg::U_BRANCH);
		end
		// [RULE_11] lowest rank in the group wins
		for (int u = 0; u < NU; u++) begin
			grant[u] = storeReq[u];
			for (int v = 0; v < u; v++) begin
				if (storeReq[v] && rsv_pkg::UNIT_GROUP[v] == rsv_pkg::UNIT_GROUP[u]) begin
					grant[u] = 1'b0;
				end
			end
			if (grant[u]) begin
				storeGoD[u] = 1'b1;
				writtenD[u] = 1'b1;
				// [RULE_01] drive the group's result trunk
				trunkD[rsv_pkg::UNIT_TRUNK[u]] = 1'b1;
				// [RULE_02] shift second result on its own trunk
				if (u == rsv_pkg::U_SHIFT && sameReg(dst1Q[u], dst1Q[u])) begin
					trunkD[rsv_pkg::SHIFT_B_TRUNK] = 1'b1;
				end
			end
		end
		// [RULE_09] a result granted now is fetchable in its write cycle
		for (int u = 0; u < NU; u++) begin
			readReq[u] = busyQ[u] && !readDoneQ[u] && ((depQ[u] & busyQ & ~writtenQ & ~grant) == '0);
		end
		// [RULE_08] both operands in one fetch, one unit per group
		for (int u = 0; u < NU; u++) begin
			if (readReq[u]) begin
				readGoD[u] = 1'b1;
				for (int v = 0; v < u; v++) begin
					if (readReq[v] && rsv_pkg::UNIT_GROUP[v] == rsv_pkg::UNIT_GROUP[u]) begin
						readGoD[u] = 1'b0;
					end
				end
			end
			if (readGoD[u]) begin
				readDoneD[u] = 1'b1;
				for (int w = 0; w < NU; w++) begin
					waitD[w][u] = 1'b0;
				end
			end
		end
		for (int u = 0; u < NU; u++) begin
			// [RULE_09] release reservation one cycle after the store
			if (storeGoQ[u]) begin
				busyD[u] = 1'b0;
				if (sameReg(dst0Q[u], dst0Q[u])) begin
					resvD[dst0Q[u]] = 1'b0;
				end
				if (sameReg(dst1Q[u], dst1Q[u])) begin
					resvD[dst1Q[u]] = 1'b0;
				end
				for (int w = 0; w < NU; w++) begin
					depD[w][u] = 1'b0;
				end
			end
			// branch unit frees once it has fetched and finished
			if (u == rsv_pkg::U_BRANCH && busyQ[u] && readDoneQ[u] && unitDone[u]) begin
				busyD[u] = 1'b0;
			end
		end
		// [RULE_03] reserve results at issue; set after clears
		if (issueOk) begin
			busyD[unitSel] = 1'b1;
			readDoneD[unitSel] = 1'b0;
			writtenD[unitSel] = 1'b0;
			dst0D[unitSel] = decD0;
			dst1D[unitSel] = decD1;
			src0D[unitSel] = decS0;
			src1D[unitSel] = decS1;
			waitD[unitSel] = busyQ & ~readDoneD;
			for (int v = 0; v < NU; v++) begin
				depD[unitSel][v] = busyQ[v] && !writtenQ[v] && !grant[v]
					&& (sameReg(dst0Q[v], decS0) || sameReg(dst0Q[v], decS1)
					|| sameReg(dst1Q[v], decS0) || sameReg(dst1Q[v], decS1));
			end
			if (sameReg(decD0, decD0)) begin
				resvD[decD0] = 1'b1;
			end
			if (sameReg(decD1, decD1)) begin
				resvD[decD1] = 1'b1;
			end
		end
		issueTakenD = issueOk;
		issueUnitD = issueOk ? 4'(unitSel) : issueUnitQ;
		issueStallD = issueValid && !issueOk && !issueTakenQ;
	end

	// registers only
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			resvQ <= rsv_pkg::RESV_RESET;
			busyQ <= rsv_pkg::UNIT_RESET;
			readDoneQ <= rsv_pkg::UNIT_RESET;
			writtenQ <= rsv_pkg::UNIT_RESET;
			readGoQ <= rsv_pkg::UNIT_RESET;
			storeGoQ <= rsv_pkg::UNIT_RESET;
			trunkActiveQ <= '0;
			issueTakenQ <= 1'b0;
			issueUnitQ <= '0;
			issueStallQ <= 1'b0;
			for (int u = 0; u < NU; u++) begin
				dst0Q[u] <= rsv_pkg::REG_NONE;
				dst1Q[u] <= rsv_pkg::REG_NONE;
				src0Q[u] <= rsv_pkg::REG_NONE;
				src1Q[u] <= rsv_pkg::REG_NONE;
				depQ[u] <= rsv_pkg::UNIT_RESET;
				waitQ[u] <= rsv_pkg::UNIT_RESET;
			end
		end else begin
			resvQ <= resvD;
			busyQ <= busyD;
			readDoneQ <= readDoneD;
			writtenQ <= writtenD;
			readGoQ <= readGoD;
			storeGoQ <= storeGoD;
			trunkActiveQ <= trunkD;
			issueTakenQ <= issueTakenD;
			issueUnitQ <= issueUnitD;
			issueStallQ <= issueStallD;
			dst0Q <= dst0D;
			dst1Q <= dst1D;
			src0Q <= src0D;
			src1Q <= src1D;
			depQ <= depD;
			waitQ <= waitD;
		end
	end

endmodule // rsv_scoreboard

// ===== verif/rsv_scoreboard_monitor.sv
`timescale 1ns/1ps
module rsv_scoreboard_monitor (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [9:0] unitDone,
	input wire logic issueTakenQ,
	input wire logic [3:0] issueUnitQ,
	input wire logic issueStallQ,
	input wire logic [9:0] readGoQ,
	input wire logic [9:0] storeGoQ,
	input wire logic [9:0] busyQ,
	input wire logic [10:0] trunkActiveQ
);
	// ==========================================
	// port checks
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	chk_take_pulse: assert property (issueTakenQ |=> !issueTakenQ)
		else $error("issue taken twice running");
	chk_take_busy: assert property (issueTakenQ |-> busyQ[issueUnitQ] && !issueStallQ)
		else $error("taken unit not busy");
	chk_read_busy: assert property ((readGoQ & ~busyQ) == 10'h000)
		else $error("fetch on idle unit");
	chk_read_group: assert property ($onehot0(readGoQ[2:0]) && $onehot0(readGoQ[6:3])
		&& $onehot0(readGoQ[8:7])) else $error("two fetches in a group");
	chk_store_group: assert property ($onehot0(storeGoQ[2:0]) && $onehot0(storeGoQ[6:3])
		&& $onehot0(storeGoQ[8:7])) else $error("two stores on a trunk");
	chk_trunk_map: assert property ((trunkActiveQ[3] == (|storeGoQ[2:0]))
		&& (trunkActiveQ[7] == (|storeGoQ[6:3])) && (trunkActiveQ[10] == (|storeGoQ[8:7])))
		else $error("trunk use does not match stores");
	chk_trunk_spare: assert property ((trunkActiveQ & 11'h367) == 11'h000)
		else $error("unused trunk active");
	chk_shift_pair: assert property (trunkActiveQ[4] |-> storeGoQ[0])
		else $error("second trunk without shift store");
	chk_store_free: assert property (|storeGoQ |=> (busyQ & $past(storeGoQ)) == 10'h000)
		else $error("unit not freed after store");
	chk_store_done: assert property ((storeGoQ & ~$past(unitDone)) == 10'h000)
		else $error("store without result");
	cover property (issueStallQ);
	cover property (trunkActiveQ[4]);
	cover property (storeGoQ[1] ##[1:4] storeGoQ[2]);
endmodule // rsv_scoreboard_monitor

bind rsv_scoreboard rsv_scoreboard_monitor mon (.mclk(mclk), .rst_n(rst_n), .unitDone(unitDone),
	.issueTakenQ(issueTakenQ), .issueUnitQ(issueUnitQ), .issueStallQ(issueStallQ),
	.readGoQ(readGoQ), .storeGoQ(storeGoQ), .busyQ(busyQ), .trunkActiveQ(trunkActiveQ));

// ===== verif/rsv_scoreboard_tb.sv
`timescale 1ns/1ps
module rsv_scoreboard_tb;
	logic mclk, rst_n, issueValid, issueTakenQ, issueStallQ;
	logic [5:0] issueOp;
	logic [2:0] issueI, issueJ, issueK, issueAddrHi;
	logic [3:0] issueUnitQ;
	logic [9:0] unitDone, holdMask, readGoQ, storeGoQ, busyQ;
	logic [23:0] reservedRegsQ;
	logic [10:0] trunkActiveQ;
	int err_count, comparisons;
	rsv_scoreboard uut (.mclk(mclk), .rst_n(rst_n), .issueValid(issueValid), .issueOp(issueOp),
		.issueI(issueI), .issueJ(issueJ), .issueK(issueK), .issueAddrHi(issueAddrHi),
		.unitDone(unitDone), .issueTakenQ(issueTakenQ), .issueUnitQ(issueUnitQ),
		.issueStallQ(issueStallQ), .readGoQ(readGoQ), .storeGoQ(storeGoQ), .busyQ(busyQ),
		.reservedRegsQ(reservedRegsQ), .trunkActiveQ(trunkActiveQ));
	rsv_unit_model far (.mclk(mclk), .rst_n(rst_n), .holdMask(holdMask), .readGoQ(readGoQ),
		.storeGoQ(storeGoQ), .busyQ(busyQ), .unitDone(unitDone));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hold one instruction until taken, then let the refused taken cycle pass
	task automatic issue(logic [5:0] op, logic [2:0] i, j, k, hi);
		{issueOp, issueI, issueJ, issueK, issueAddrHi} = {op, i, j, k, hi};
		issueValid = 1'b1;
		@(negedge mclk);
		for (int c = 0; c < 40 && issueTakenQ !== 1'b1; c++)
			@(negedge mclk);
		check("taken", issueTakenQ, 1'b1);
		issueValid = 1'b0;
		@(negedge mclk);
	endtask
	task automatic wait_store(int u);
		for (int c = 0; c < 40 && storeGoQ[u] !== 1'b1; c++)
			@(negedge mclk);
	endtask
	task automatic idle;
		for (int c = 0; c < 40 && busyQ !== 10'h000; c++)
			@(negedge mclk);
		check("busy", busyQ, 24'h0);
		check("resv", reservedRegsQ, 24'h0);
	endtask
	task automatic t_basic;
		issue(6'o10, 3'h1, 3'h2, 3'h3, 3'h0);
		check("unit", issueUnitQ, 24'(rsv_pkg::U_BOOL));
		check("resv", reservedRegsQ, 24'h000002);
		wait_store(3);
		check("trunk", trunkActiveQ, 24'h000080);
		check("held", reservedRegsQ, 24'h000002);
		idle();
	endtask
	task automatic t_resv;
		logic [5:0] ops [5] = '{6'o24, 6'o50, 6'o50, 6'o64, 6'o04};
		logic [2:0] ri [5] = '{3'h2, 3'h0, 3'h3, 3'h5, 3'h1};
		logic [23:0] ex [5] = '{24'h002004, 24'h010000, 24'h080008, 24'h002000, 24'h0};
		for (int n = 0; n < 5; n++) begin
			issue(ops[n], ri[n], 3'h5, 3'h1, 3'h1);
			check("resv", reservedRegsQ, ex[n]);
			if (n == 0) begin
				wait_store(0);
				check("pair", trunkActiveQ, 24'h000018);
			end
			idle();
		end
	endtask
	task automatic t_stall;
		holdMask = 10'h008;
		issue(6'o10, 3'h1, 3'h2, 3'h3, 3'h0);
		issueOp = 6'o30;
		issueValid = 1'b1;
		repeat (3) @(negedge mclk);
		check("stall", issueStallQ, 1'b1);
		check("take", issueTakenQ, 1'b0);
		{issueOp, issueI} = {6'o11, 3'h7};
		repeat (2) @(negedge mclk);
		check("busy stall", issueStallQ, 1'b1);
		check("busy take", issueTakenQ, 1'b0);
		holdMask = 10'h000;
		issue(6'o30, 3'h1, 3'h2, 3'h3, 3'h0);
		check("unit", issueUnitQ, 24'(rsv_pkg::U_FADD));
		idle();
	endtask
	task automatic t_war;
		int fs = 99, fr = -1, fw = -1;
		holdMask = 10'h002;
		issue(6'o30, 3'h4, 3'h1, 3'h2, 3'h0);
		issue(6'o40, 3'h5, 3'h6, 3'h4, 3'h0);
		issue(6'o10, 3'h6, 3'h1, 3'h2, 3'h0);
		repeat (4) @(negedge mclk);
		holdMask = 10'h000;
		for (int c = 0; c < 30; c++) begin
			@(negedge mclk);
			if (storeGoQ[1]) fs = c;
			if (readGoQ[5]) fr = c;
			if (storeGoQ[3]) fw = c;
		end
		check("fetch", fr >= fs, 1'b1);
		check("hold", fw > fr, 1'b1);
		idle();
	endtask
	task automatic t_addr;
		logic acc = 1'b0;
		holdMask = 10'h080;
		issue(6'o64, 3'h2, 3'h1, 3'h1, 3'h0);
		issue(6'o60, 3'h3, 3'h1, 3'h0, 3'h2);
		acc = readGoQ[8];
		repeat (6) @(negedge mclk) acc |= readGoQ[8];
		check("hi", acc, 1'b0);
		holdMask = 10'h000;
		idle();
	endtask
	task automatic t_prio;
		holdMask = 10'h006;
		issue(6'o30, 3'h1, 3'h2, 3'h3, 3'h0);
		issue(6'o36, 3'h2, 3'h3, 3'h4, 3'h0);
		repeat (3) @(negedge mclk);
		holdMask = 10'h000;
		for (int c = 0; c < 20 && storeGoQ[2:0] === 3'h0; c++)
			@(negedge mclk);
		check("rank", storeGoQ[2:0], 3'h2);
		wait_store(2);
		check("later", storeGoQ[2], 1'b1);
		idle();
	endtask
	initial begin
		rst_n = 1'b0;
		issueValid = 1'b0;
		{issueOp, issueI, issueJ, issueK, issueAddrHi} = 18'h0;
		holdMask = 10'h000;
		err_count = 0;
		comparisons = 0;
		repeat (6) @(negedge mclk);
		check("reset", reservedRegsQ, 24'h0);
		rst_n = 1'b1;
		@(negedge mclk);
		t_basic();
		t_resv();
		t_stall();
		t_war();
		t_addr();
		t_prio();
		tally_and_finish();
	end
	initial begin
		#20000;
		err_count++;
		tally_and_finish();
	end
endmodule // rsv_scoreboard_tb

// ===== verif/rsv_unit_model.sv
`timescale 1ns/1ps
module rsv_unit_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [9:0] holdMask,
	input wire logic [9:0] readGoQ,
	input wire logic [9:0] storeGoQ,
	input wire logic [9:0] busyQ,
	output logic [9:0] unitDone
);
	// result ready one cycle after fetch, held until stored or freed
	logic [9:0] doneQ;
	always_ff @(posedge mclk) begin
		if (!rst_n)
			doneQ <= 10'h000;
		else
			doneQ <= (doneQ | readGoQ) & ~storeGoQ & busyQ;
	end
	// stalled units keep their result back
	assign unitDone = doneQ & ~holdMask;
endmodule // rsv_unit_model
